// [rtl/cbps_map.vh]
// Register offsets, field positions, reset values and widths for the generator core.
`ifndef CBPS_MAP_VH
`define CBPS_MAP_VH
`define CBPS_ADDR_W        3
`define CBPS_DATA_W        8
`define CBPS_OFF_CTRL      3'h0
`define CBPS_OFF_BLANK     3'h1
`define CBPS_OFF_PHASE     3'h2
`define CBPS_OFF_DEADBAND  3'h3
`define CBPS_OFF_SHUTDOWN  3'h4
`define CBPS_OFF_STATUS    3'h5
`define CBPS_CTRL_EN       7
`define CBPS_CTRL_LD       2
`define CBPS_BLK_RISE_LSB  4
`define CBPS_BLK_FALL_LSB  0
`define CBPS_DB_RISE_LSB   4
`define CBPS_DB_FALL_LSB   0
`define CBPS_SD_ACTIVE     7
`define CBPS_SD_ARST       6
`define CBPS_SD_LVL1       5
`define CBPS_SD_LVL0       4
`define CBPS_SD_SRC_LSB    0
`define CBPS_SD_RESET      8'h80
`define CBPS_CNT_W         4
`define CBPS_CNT_ZERO      4'h0
`endif

// [rtl/cbps_generator.v]
// Complementary generator core: blanking, phase delay, dead band and auto-shutdown.
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "cbps_map.vh"

module cbps_generator (
    // Clock and reset.
    input  wire                     sys_clk,
    input  wire                     reset,
    // Register port.
    input  wire [`CBPS_ADDR_W-1:0]  regAddr,
    input  wire [`CBPS_DATA_W-1:0]  regWrData,
    input  wire                     regWrite,
    input  wire                     regRead,
    output reg  [`CBPS_DATA_W-1:0]  regRdData,
    // Generator clock enable from the clock divider.
    input  wire                     generatorClockTick,
    // Event inputs, already selected.
    input  wire                     risingEventIn,
    input  wire                     fallingEventIn,
    // Shutdown sources.
    input  wire                     limitTimerOutput,
    input  wire                     secondComparatorOutput,
    input  wire                     firstComparatorOutput,
    input  wire                     faultInputPin_n,
    // Drive outputs.
    output reg                      primaryDriveOutput,
    output reg                      complementaryDriveOutput
);
    localparam W = `CBPS_CNT_W;

    reg         enable_r;
    reg         load_r;
    reg [7:0]   blankReg_r, phaseReg_r, dbReg_r;
    reg [7:0]   blankBuf_r, phaseBuf_r, dbBuf_r;
    reg         shutdownActive_r;
    reg         autoRestart_r;
    reg [1:0]   overrideLevel_r;
    reg [3:0]   sourceEnable_r;
    reg         risePrev_r, fallPrev_r;
    reg         out0_r, out1_r;
    reg [W-1:0] fallBlankCnt_r, riseBlankCnt_r, phaseCnt_r, dbRiseCnt_r, dbFallCnt_r;
    reg         fallBlankRun_r, riseBlankRun_r, phaseRun_r, dbRiseRun_r, dbFallRun_r;
    reg         waitRise_r;

    wire [W-1:0] fallBlankCount = blankBuf_r[`CBPS_BLK_FALL_LSB +: W];
    wire [W-1:0] riseBlankCount = blankBuf_r[`CBPS_BLK_RISE_LSB +: W];
    wire [W-1:0] phaseCount     = phaseBuf_r[W-1:0];
    wire [W-1:0] dbRiseCount    = dbBuf_r[`CBPS_DB_RISE_LSB +: W];
    wire [W-1:0] dbFallCount    = dbBuf_r[`CBPS_DB_FALL_LSB +: W];

    // Three comparator and pin sources are low true.
    wire [3:0] faultLevels = {limitTimerOutput, ~secondComparatorOutput,
                              ~firstComparatorOutput, ~faultInputPin_n};
    wire       faultActive = |(faultLevels & sourceEnable_r);

    wire riseEdge = risingEventIn & ~risePrev_r;
    wire fallEdge = ~fallingEventIn & fallPrev_r;
    // Blanking passes straight through when its count is zero.
    wire riseUnblanked = riseEdge & ~fallBlankRun_r;
    wire fallUnblanked = fallEdge & ~riseBlankRun_r;
    // A zero phase count hands the event on in the same cycle.
    wire riseToDb = (riseUnblanked & (phaseCount == `CBPS_CNT_ZERO))
                  | (phaseRun_r & generatorClockTick & (phaseCnt_r == phaseCount));
    wire halted = shutdownActive_r | faultActive | waitRise_r | ~enable_r;

    wire wrCtrl  = regWrite & (regAddr == `CBPS_OFF_CTRL);
    wire wrBlank = regWrite & (regAddr == `CBPS_OFF_BLANK);
    wire wrPhase = regWrite & (regAddr == `CBPS_OFF_PHASE);
    wire wrDb    = regWrite & (regAddr == `CBPS_OFF_DEADBAND);
    wire wrSd    = regWrite & (regAddr == `CBPS_OFF_SHUTDOWN);

    // Register writes, buffered counts and the load handshake.
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            enable_r        <= 1'b0;
            load_r          <= 1'b0;
            blankReg_r      <= 8'h00;
            phaseReg_r      <= 8'h00;
            dbReg_r         <= 8'h00;
            blankBuf_r      <= 8'h00;
            phaseBuf_r      <= 8'h00;
            dbBuf_r         <= 8'h00;
            autoRestart_r   <= 1'b0;
            overrideLevel_r <= 2'h0;
            sourceEnable_r  <= 4'h0;
        end else begin
            if (wrCtrl) begin
                enable_r <= regWrData[`CBPS_CTRL_EN];
            end
            if (wrBlank) begin
                blankReg_r <= regWrData;
            end
            if (wrPhase) begin
                phaseReg_r <= {4'h0, regWrData[W-1:0]};
            end
            if (wrDb) begin
                dbReg_r <= regWrData;
            end
            if (wrSd) begin
                autoRestart_r   <= regWrData[`CBPS_SD_ARST];
                overrideLevel_r <= {regWrData[`CBPS_SD_LVL1], regWrData[`CBPS_SD_LVL0]};
                sourceEnable_r  <= regWrData[`CBPS_SD_SRC_LSB +: 4];
            end
            if (!enable_r) begin
                // Disabled: writes reach the working buffers at once.
                if (wrBlank) blankBuf_r <= regWrData;
                if (wrPhase) phaseBuf_r <= {4'h0, regWrData[W-1:0]};
                if (wrDb)    dbBuf_r    <= regWrData;
                load_r <= 1'b0;
            end else if (load_r & generatorClockTick) begin
                // Transfer on a generator clock tick, then clear the load bit.
                blankBuf_r <= blankReg_r;
                phaseBuf_r <= phaseReg_r;
                dbBuf_r    <= dbReg_r;
                load_r     <= 1'b0;
            end else if (wrCtrl & regWrData[`CBPS_CTRL_LD]) begin
                load_r <= 1'b1;
            end
        end
    end

    // Shutdown bit: set by software, by fault, cleared by software or restart.
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            shutdownActive_r <= 1'b1;
            waitRise_r       <= 1'b1;
        end else begin
            if (faultActive) begin
                shutdownActive_r <= 1'b1;
            end else if (wrSd) begin
                // Clearing fails while a selected source is true.
                shutdownActive_r <= regWrData[`CBPS_SD_ACTIVE];
            end else if (autoRestart_r) begin
                shutdownActive_r <= 1'b0;
            end
            // Resume only on the first rising event after release.
            if (shutdownActive_r | faultActive | ~enable_r) begin
                waitRise_r <= 1'b1;
            end else if (riseEdge) begin
                waitRise_r <= 1'b0;
            end
        end
    end

    // Timing chain: blanking, then phase delay, then dead band.
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            risePrev_r     <= 1'b0;
            fallPrev_r     <= 1'b0;
            out0_r         <= 1'b0;
            out1_r         <= 1'b1;
            fallBlankCnt_r <= `CBPS_CNT_ZERO;
            riseBlankCnt_r <= `CBPS_CNT_ZERO;
            phaseCnt_r     <= `CBPS_CNT_ZERO;
            dbRiseCnt_r    <= `CBPS_CNT_ZERO;
            dbFallCnt_r    <= `CBPS_CNT_ZERO;
            fallBlankRun_r <= 1'b0;
            riseBlankRun_r <= 1'b0;
            phaseRun_r     <= 1'b0;
            dbRiseRun_r    <= 1'b0;
            dbFallRun_r    <= 1'b0;
        end else if (!enable_r || shutdownActive_r || faultActive) begin
            // Counters idle and drive latches reset.
            risePrev_r     <= risingEventIn;
            fallPrev_r     <= fallingEventIn;
            out0_r         <= 1'b0;
            out1_r         <= 1'b1;
            fallBlankCnt_r <= `CBPS_CNT_ZERO;
            riseBlankCnt_r <= `CBPS_CNT_ZERO;
            phaseCnt_r     <= `CBPS_CNT_ZERO;
            dbRiseCnt_r    <= `CBPS_CNT_ZERO;
            dbFallCnt_r    <= `CBPS_CNT_ZERO;
            fallBlankRun_r <= 1'b0;
            riseBlankRun_r <= 1'b0;
            phaseRun_r     <= 1'b0;
            dbRiseRun_r    <= 1'b0;
            dbFallRun_r    <= 1'b0;
        end else begin
            risePrev_r <= risingEventIn;
            fallPrev_r <= fallingEventIn;
            // Counting starts at zero on the event, not on a tick, so asynchronous starts
            // land within one generator period of the count.
            if (fallUnblanked) begin
                out0_r      <= 1'b0;
                dbRiseRun_r <= 1'b0;
                phaseRun_r  <= 1'b0;
                // Drive off starts blanking of rising inputs when enabled.
                fallBlankRun_r <= (fallBlankCount != `CBPS_CNT_ZERO);
                fallBlankCnt_r <= `CBPS_CNT_ZERO;
                dbFallRun_r <= (dbFallCount != `CBPS_CNT_ZERO);
                dbFallCnt_r <= `CBPS_CNT_ZERO;
                if (dbFallCount == `CBPS_CNT_ZERO) out1_r <= 1'b1;
            end else if (!waitRise_r && riseUnblanked) begin
                // Phase delay stage follows blanking.
                phaseRun_r <= (phaseCount != `CBPS_CNT_ZERO);
                phaseCnt_r <= `CBPS_CNT_ZERO;
                if (phaseCount == `CBPS_CNT_ZERO) begin
                    out1_r <= 1'b0;
                end
                // Rising event starts blanking of falling inputs when enabled.
                riseBlankRun_r <= (riseBlankCount != `CBPS_CNT_ZERO);
                riseBlankCnt_r <= `CBPS_CNT_ZERO;
            end
            if (generatorClockTick) begin
                if (fallBlankRun_r) begin
                    fallBlankCnt_r <= fallBlankCnt_r + 1'b1;
                    // Ending at the count itself keeps a partial first period
                    // from shortening the window below the full count.
                    if (fallBlankCnt_r == fallBlankCount) fallBlankRun_r <= 1'b0;
                end
                if (riseBlankRun_r) begin
                    riseBlankCnt_r <= riseBlankCnt_r + 1'b1;
                    if (riseBlankCnt_r == riseBlankCount) riseBlankRun_r <= 1'b0;
                end
                if (phaseRun_r) begin
                    phaseCnt_r <= phaseCnt_r + 1'b1;
                    if (phaseCnt_r == phaseCount) begin
                        phaseRun_r <= 1'b0;
                        out1_r     <= 1'b0;
                    end
                end
                if (dbRiseRun_r) begin
                    dbRiseCnt_r <= dbRiseCnt_r + 1'b1;
                    if (dbRiseCnt_r == dbRiseCount) begin
                        dbRiseRun_r <= 1'b0;
                        out0_r      <= 1'b1;
                    end
                end
                if (dbFallRun_r) begin
                    dbFallCnt_r <= dbFallCnt_r + 1'b1;
                    if (dbFallCnt_r == dbFallCount) begin
                        dbFallRun_r <= 1'b0;
                        out1_r      <= 1'b1;
                    end
                end
            end
            // Dead band follows the phase stage output.
            if (!waitRise_r && riseToDb && !fallUnblanked) begin
                if (dbRiseCount == `CBPS_CNT_ZERO) begin
                    out0_r <= 1'b1;
                end else begin
                    dbRiseRun_r <= 1'b1;
                    dbRiseCnt_r <= `CBPS_CNT_ZERO;
                end
            end
        end
    end

    // Pins: override levels while halted, no inversion.
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            primaryDriveOutput       <= 1'b0;
            complementaryDriveOutput <= 1'b0;
        end else if (halted || faultActive) begin
            primaryDriveOutput       <= overrideLevel_r[0];
            complementaryDriveOutput <= overrideLevel_r[1];
        end else begin
            primaryDriveOutput       <= out0_r;
            complementaryDriveOutput <= out1_r;
        end
    end

    // Read port, data in the following cycle.
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            regRdData <= 8'h00;
        end else if (regRead) begin
            case (regAddr)
                `CBPS_OFF_CTRL:     regRdData <= {enable_r, 4'h0, load_r, 2'h0};
                `CBPS_OFF_BLANK:    regRdData <= blankReg_r;
                `CBPS_OFF_PHASE:    regRdData <= phaseReg_r;
                `CBPS_OFF_DEADBAND: regRdData <= dbReg_r;
                `CBPS_OFF_SHUTDOWN: regRdData <= {shutdownActive_r, autoRestart_r,
                                                  overrideLevel_r, sourceEnable_r};
                `CBPS_OFF_STATUS:   regRdData <= {3'h0, faultActive, waitRise_r,
                                                  phaseRun_r, out1_r, out0_r};
                default:            regRdData <= 8'h00;
            endcase
        end else begin
            regRdData <= 8'h00;
        end
    end
endmodule // cbps_generator

// [sim/cbps_generator_monitor.sv]
// Port-level assertions for the complementary generator core.
`timescale 1ns/1ps
`include "cbps_map.vh"
module cbps_generator_monitor (
    // Clock and reset.
    input wire                    sys_clk,
    input wire                    reset,
    // Register port.
    input wire [`CBPS_ADDR_W-1:0] regAddr,
    input wire [`CBPS_DATA_W-1:0] regWrData,
    input wire                    regWrite,
    input wire                    regRead,
    input wire [`CBPS_DATA_W-1:0] regRdData,
    // Events, shutdown sources and drive outputs.
    input wire                    generatorClockTick,
    input wire                    risingEventIn,
    input wire                    fallingEventIn,
    input wire                    limitTimerOutput,
    input wire                    secondComparatorOutput,
    input wire                    firstComparatorOutput,
    input wire                    faultInputPin_n,
    input wire                    primaryDriveOutput,
    input wire                    complementaryDriveOutput
);
    // Shadows of written fields; counts are only trusted when written while disabled.
    reg  [7:0] sdReg_r;
    reg  [7:0] blkReg_r;
    reg        enable_r;
    wire [1:0] outs = {primaryDriveOutput, complementaryDriveOutput};
    wire [1:0] lvls = {sdReg_r[`CBPS_SD_LVL0], sdReg_r[`CBPS_SD_LVL1]};
    wire [3:0] srcLive = {limitTimerOutput, ~secondComparatorOutput,
                          ~firstComparatorOutput, ~faultInputPin_n};
    wire       faultNow = |(srcLive & sdReg_r[3:0]);
    wire       sdRead = regRead && (regAddr == `CBPS_OFF_SHUTDOWN);
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sdReg_r <= `CBPS_SD_RESET;
            blkReg_r <= 8'h00;
            enable_r <= 1'b0;
        end else if (regWrite) begin
            if (regAddr == `CBPS_OFF_SHUTDOWN) sdReg_r <= regWrData;
            if (regAddr == `CBPS_OFF_BLANK) blkReg_r <= regWrData;
            if (regAddr == `CBPS_OFF_CTRL) enable_r <= regWrData[`CBPS_CTRL_EN];
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    rd_idle_zero_a: assert property (!regRead |=> regRdData == 8'h00)
        else $error("read data not zero outside a read answer");
    unmapped_zero_a: assert property (regRead && regAddr > `CBPS_OFF_STATUS |=> regRdData == 8'h00)
        else $error("unmapped read returned data");
    fault_override_a: assert property ((faultNow && !regWrite) [*4] |-> outs == lvls)
        else $error("fault did not force override levels");
    no_overlap_a: assert property (primaryDriveOutput && complementaryDriveOutput |-> lvls == 2'b11)
        else $error("both drives high outside override");
    fault_bit_a: assert property (faultNow [*4] ##0 sdRead |=> regRdData[`CBPS_SD_ACTIVE])
        else $error("shutdown bit clear during fault");
    idle_override_a: assert property ((!enable_r && !regWrite) [*4] |-> outs == lvls)
        else $error("disabled generator not at override levels");
    auto_clear_a: assert property ((sdReg_r[`CBPS_SD_ARST] && !faultNow && !regWrite) [*6] ##0 sdRead
        |=> !regRdData[`CBPS_SD_ACTIVE])
        else $error("auto restart left shutdown bit set");
    fall_clears_a: assert property ($fell(fallingEventIn) && outs == 2'b10 && lvls != 2'b10 && enable_r
        && !faultNow && blkReg_r[7:4] == 4'h0 |-> ##[2:3] !primaryDriveOutput)
        else $error("falling event did not clear primary drive");
    cover property (faultNow [*4]);
    cover property ($fell(fallingEventIn) && outs == 2'b10);
    cover property (sdReg_r[`CBPS_SD_ARST] && sdRead);
endmodule // cbps_generator_monitor

bind cbps_generator cbps_generator_monitor i_mon (.sys_clk, .reset, .regAddr, .regWrData,
    .regWrite, .regRead, .regRdData, .generatorClockTick, .risingEventIn, .fallingEventIn,
    .limitTimerOutput, .secondComparatorOutput, .firstComparatorOutput, .faultInputPin_n,
    .primaryDriveOutput, .complementaryDriveOutput);

// [sim/cbps_fault_src.sv]
// Behavioural fault sources that feed the shutdown inputs.
`timescale 1ns/1ps
module cbps_fault_src (
    // Clock.
    input  wire       sys_clk,
    // Fault requests: {limit timer, second comparator, first comparator, fault pin}.
    input  wire [3:0] faultReq,
    // Source levels as the sources present them.
    output reg        limitTimerOutput,
    output reg        secondComparatorOutput,
    output reg        firstComparatorOutput,
    output reg        faultInputPin_n
);
    // Only the limit timer signals high; the others are low true.
    initial begin
        limitTimerOutput = 1'b0;
        secondComparatorOutput = 1'b1;
        firstComparatorOutput = 1'b1;
        faultInputPin_n = 1'b1;
    end
    always @(posedge sys_clk) begin
        limitTimerOutput <= faultReq[3];
        secondComparatorOutput <= ~faultReq[2];
        firstComparatorOutput <= ~faultReq[1];
        faultInputPin_n <= ~faultReq[0];
    end
endmodule // cbps_fault_src

// [sim/tb_complementary_blanking_phase_shutdown.sv]
// Self-checking bench for the complementary generator core.
`timescale 1ns/1ps
`include "cbps_map.vh"
module tb_complementary_blanking_phase_shutdown;
    localparam integer TP = 4;
    reg        sys_clk = 1'b0;
    reg        reset = 1'b1;
    reg  [2:0] regAddr = 3'h0;
    reg  [7:0] regWrData = 8'h00;
    reg        regWrite = 1'b0;
    reg        regRead = 1'b0;
    reg        generatorClockTick = 1'b0;
    reg        risingEventIn = 1'b0;
    reg        fallingEventIn = 1'b0;
    reg  [3:0] faultReq = 4'h0;
    reg  [1:0] tickCnt = 2'h0;
    reg  [7:0] rdVal;
    wire [7:0] regRdData;
    wire       limitTimerOutput, secondComparatorOutput, firstComparatorOutput, faultInputPin_n;
    wire       primaryDriveOutput, complementaryDriveOutput;
    wire [7:0] outs8 = {6'h00, primaryDriveOutput, complementaryDriveOutput};
    integer    errors = 0;
    integer    total_checks = 0;
    integer    i, n;
    cbps_generator i_dut (.sys_clk, .reset, .regAddr, .regWrData, .regWrite, .regRead,
        .regRdData, .generatorClockTick, .risingEventIn, .fallingEventIn, .limitTimerOutput,
        .secondComparatorOutput, .firstComparatorOutput, .faultInputPin_n,
        .primaryDriveOutput, .complementaryDriveOutput);
    cbps_fault_src i_src (.sys_clk, .faultReq, .limitTimerOutput, .secondComparatorOutput,
        .firstComparatorOutput, .faultInputPin_n);
    initial forever #2.5 sys_clk = ~sys_clk;
    // Generator clock is a quarter of the system clock so count windows stay visible.
    always @(posedge sys_clk) begin
        tickCnt <= tickCnt + 2'h1;
        generatorClockTick <= (tickCnt == 2'h3);
    end
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task wt(input integer k);
        repeat (k) @(posedge sys_clk);
    endtask
    task wr(input [2:0] a, input [7:0] d);
        begin
            @(posedge sys_clk);
            regAddr <= a;
            regWrData <= d;
            regWrite <= 1'b1;
            @(posedge sys_clk);
            regWrite <= 1'b0;
        end
    endtask
    task rd(input [2:0] a);
        begin
            @(posedge sys_clk);
            regAddr <= a;
            regRead <= 1'b1;
            @(posedge sys_clk);
            regRead <= 1'b0;
            #1 rdVal = regRdData;
        end
    endtask
    task pr;
        begin
            @(posedge sys_clk) risingEventIn <= 1'b1;
            wt(2);
            risingEventIn <= 1'b0;
        end
    endtask
    task pf;
        begin
            @(posedge sys_clk) fallingEventIn <= 1'b1;
            wt(1);
            fallingEventIn <= 1'b0;
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d errors %0d", total_checks, errors);
            if (errors == 0 && total_checks > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task t_reset_levels;
        begin
            rd(`CBPS_OFF_SHUTDOWN);
            chk(rdVal, `CBPS_SD_RESET);
            rd(3'h7);
            chk(rdVal, 8'h00);
            chk(outs8, 8'h00);
            wr(`CBPS_OFF_SHUTDOWN, 8'hA0);
            wt(4);
            chk(outs8, 8'h01);
            wr(`CBPS_OFF_SHUTDOWN, 8'h90);
            pr;
            wt(4);
            chk(outs8, 8'h02);
        end
    endtask
    task t_run_fault;
        begin
            wr(`CBPS_OFF_CTRL, 8'h80);
            wr(`CBPS_OFF_SHUTDOWN, 8'h0F);
            pr;
            for (i = 0; i < 4; i = i + 1) begin
                pr;
                wt(4);
                chk(outs8, 8'h02);
                faultReq <= 4'h1 << i[1:0];
                wt(5);
                chk(outs8, 8'h00);
                wr(`CBPS_OFF_SHUTDOWN, 8'h0F);
                rd(`CBPS_OFF_SHUTDOWN);
                chk(rdVal, 8'h8F);
                faultReq <= 4'h0;
                wr(`CBPS_OFF_SHUTDOWN, 8'h0F);
                rd(`CBPS_OFF_SHUTDOWN);
                chk(rdVal, 8'h0F);
                pr;
            end
            pf;
            wt(4);
            chk(outs8, 8'h01);
        end
    endtask
    task t_auto;
        begin
            wr(`CBPS_OFF_SHUTDOWN, 8'hCF);
            wt(8);
            rd(`CBPS_OFF_SHUTDOWN);
            chk(rdVal, 8'h4F);
            faultReq <= 4'h8;
            wt(5);
            rd(`CBPS_OFF_SHUTDOWN);
            chk(rdVal, 8'hCF);
            faultReq <= 4'h0;
            wt(8);
            rd(`CBPS_OFF_SHUTDOWN);
            chk(rdVal, 8'h4F);
            pr;
            pr;
            wt(4);
            chk(outs8, 8'h02);
            wr(`CBPS_OFF_SHUTDOWN, 8'h0F);
            pf;
        end
    endtask
    task t_phase_load;
        begin
            wr(`CBPS_OFF_CTRL, 8'h00);
            wr(`CBPS_OFF_PHASE, 8'h03);
            wr(`CBPS_OFF_CTRL, 8'h80);
            pr;
            @(posedge sys_clk) risingEventIn <= 1'b1;
            n = 0;
            while (primaryDriveOutput !== 1'b1 && n < 100) begin
                @(posedge sys_clk);
                #1 n = n + 1;
            end
            @(posedge sys_clk) risingEventIn <= 1'b0;
            chk({7'h00, n >= 3 * TP && n <= 4 * TP + 4}, 8'h01);
            pf;
            wr(`CBPS_OFF_PHASE, 8'h00);
            wr(`CBPS_OFF_CTRL, 8'h84);
            wt(10);
            rd(`CBPS_OFF_CTRL);
            chk(rdVal, 8'h80);
            pr;
            wt(4);
            chk(outs8, 8'h02);
            pf;
        end
    endtask
    task t_blank;
        begin
            wr(`CBPS_OFF_CTRL, 8'h00);
            wr(`CBPS_OFF_BLANK, 8'h22);
            wr(`CBPS_OFF_CTRL, 8'h80);
            pr;
            pr;
            wt(3);
            pf;
            wt(3);
            chk(outs8, 8'h02);
            wt(20);
            pf;
            wt(4);
            chk(outs8, 8'h01);
            pr;
            wt(3);
            chk(outs8, 8'h01);
            wt(20);
            pr;
            wt(4);
            chk(outs8, 8'h02);
        end
    endtask
    initial begin
        wt(3);
        reset <= 1'b0;
        t_reset_levels;
        t_run_fault;
        t_auto;
        t_phase_load;
        t_blank;
        give_verdict;
    end
    initial begin
        wt(5000);
        errors = errors + 1;
        give_verdict;
    end
endmodule // tb_complementary_blanking_phase_shutdown
